//--- core/cbe_pkg.sv
// Package of types and constants for the conditional branch evaluator.
package cbe_pkg;

   // ****************************************
   // Widths and bit address map
   // ****************************************
   localparam int CBE_DATA_W = 8;
   localparam int CBE_BIT_ADDR_W = 8;
   localparam logic [7:0] CBE_SFR_SPACE_BIT = 8'h80;
   localparam logic [7:0] CBE_USER_BIT_BASE = 8'h20;
   localparam int CBE_BIT_IDX_W = 3;
   localparam int CBE_USER_BYTES = 16;
   localparam int CBE_JB_BYTES = 3;
   localparam int CBE_JC_BYTES = 2;
   localparam int CBE_STD_BYTES = 3;

   // ****************************************
   // Operation codes from the sequencer
   // ****************************************
   typedef enum logic [3:0]
   {
      CBE_OP_NONE = 4'h0,
      CBE_OP_JUMP_IF_BIT_ONE = 4'h1,
      CBE_OP_JUMP_IF_BIT_ONE_THEN_CLEAR = 4'h2,
      CBE_OP_JUMP_IF_BIT_ZERO = 4'h3,
      CBE_OP_JUMP_ON_CARRY_SET = 4'h4,
      CBE_OP_JUMP_ON_CARRY_CLEAR = 4'h5,
      CBE_OP_COMPARE_BRANCH_UNEQUAL = 4'h6,
      CBE_OP_BRANCH_ACC_IS_ZERO = 4'h7,
      CBE_OP_BRANCH_ACC_NOT_ZERO = 4'h8
   } cbe_op_t;

   typedef enum logic [1:0]
   {
      CBE_ST_IDLE = 2'b00,
      CBE_ST_FETCH = 2'b01,
      CBE_ST_DECIDE = 2'b10
   } cbe_state_t;

   typedef struct packed
   {
      cbe_op_t op;
      logic [7:0] bit_addr;
      logic [7:0] operand_a;
      logic [7:0] operand_b;
   } cbe_req_t;

   typedef struct packed
   {
      logic taken;
      logic carry_we;
      logic carry;
      logic [1:0] length;
   } cbe_resp_t;

endpackage : cbe_pkg

//--- core/cbe_bit_ram.sv
// Bit addressable user RAM, sixteen bytes with registered read.
`timescale 1ns/100ps
module cbe_bit_ram
#(
   parameter int DEPTH = 16,
   parameter int WIDTH = 8
)
(
   input wire logic core_clk, // Core clock.
   input wire logic clk_en, // Freezes state when low.
   input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read byte index.
   output logic [WIDTH-1:0] rd_data, // Registered read data.
   input wire logic wr_en, // Byte write strobe.
   input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write byte index.
   input wire logic [WIDTH-1:0] wr_data // Write data.
);

   logic [WIDTH-1:0] mem [DEPTH];

   initial
   begin
      if (DEPTH < 2 || WIDTH < 1)
      begin
         $error("cbe_bit_ram: bad size");
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (clk_en && wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (clk_en)
      begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : cbe_bit_ram

//--- core/cbe_branch_eval.sv
// Conditional branch evaluator for the 8-bit core.
`timescale 1ns/100ps
// Notes on behaviour
// (RULE1) Bit-one test branches when addressed bit set.
// (RULE2) Then-clear variant branches and clears set bit.
// (RULE3) Bit-zero test branches when bit reads zero.
// (RULE4) Carry-set test, two bytes versus three.
// (RULE5) Carry-clear test branches when carry zero.
// (RULE6) Compare branches when operands differ.
// (RULE7) Compare sets carry when first below second.
// (RULE8) Compare clears carry when first not below.
// (RULE9) Carry update happens taken or not.
// (RULE10) Accumulator-zero test branches when all bits zero.
// (RULE11) Accumulator-nonzero test branches on any one.
// (RULE12) No zero flag; accumulator read directly.
// (RULE13) Low bit addresses map to user RAM bytes.
// (RULE14) High bit addresses select SFR bits.
// (RULE15) Nothing else changes flags or operands.
module cbe_branch_eval
(
   input wire logic core_clk, // Core clock, 125 MHz.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic clk_en, // Freezes all state when low.
   input wire logic req_valid, // Request strobe from sequencer.
   input wire cbe_pkg::cbe_req_t req, // Operation and operands.
   output logic req_ready, // Ready for a new request.
   input wire logic carry_in, // Current carry flag.
   input wire logic [7:0] acc, // Current accumulator.
   output logic resp_valid, // One-cycle pulse with decision.
   output cbe_pkg::cbe_resp_t resp, // Decision, carry update, length.
   output logic [7:0] sfr_addr, // SFR byte to read or write.
   input wire logic [7:0] sfr_rd_data, // SFR byte, valid next cycle.
   output logic sfr_we, // SFR write strobe.
   output logic [7:0] sfr_wr_data, // SFR write data.
   input wire logic ram_we_ext, // Sequencer write to user bit RAM.
   input wire logic [3:0] ram_addr_ext, // Sequencer RAM byte index.
   input wire logic [7:0] ram_wdata_ext // Sequencer RAM write data.
);
   import cbe_pkg::*;

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic is_bit_op(input cbe_op_t op);
      return op == CBE_OP_JUMP_IF_BIT_ONE ||
             op == CBE_OP_JUMP_IF_BIT_ONE_THEN_CLEAR ||
             op == CBE_OP_JUMP_IF_BIT_ZERO;
   endfunction : is_bit_op

   function automatic logic [7:0] sfr_byte(input logic [7:0] a);
      return {a[7:3], 3'b000}; // see (RULE14)
   endfunction : sfr_byte

   // Carry and accumulator tests fit in two program bytes.
   function automatic logic is_short_op(input cbe_op_t op);
      return op == CBE_OP_JUMP_ON_CARRY_SET ||
             op == CBE_OP_JUMP_ON_CARRY_CLEAR ||
             op == CBE_OP_BRANCH_ACC_IS_ZERO ||
             op == CBE_OP_BRANCH_ACC_NOT_ZERO;
   endfunction : is_short_op

   // ****************************************
   // State
   // ****************************************
   cbe_state_t state;
   cbe_req_t cur;
   logic [7:0] byte_val;
   logic bit_val;
   logic in_sfr;
   logic [3:0] ram_idx;
   logic [7:0] ram_rd;
   logic ram_we;
   logic [3:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic next_taken;
   logic next_clear;
   logic [7:0] cleared_byte;

   // The user bit space must fill the lower half of the bit addresses.
   if (CBE_USER_BYTES * 8 != int'(CBE_SFR_SPACE_BIT))
   begin : g_bad_map
      $error("cbe_branch_eval: user bits do not fill lower half");
   end

   // Only an idle evaluator takes a request; an early one is not queued.
   assign req_ready = state == CBE_ST_IDLE;
   assign in_sfr = cur.bit_addr[7]; // see (RULE13) (RULE14)
   assign ram_idx = in_sfr ? 4'h0 : cur.bit_addr[6:3]; // see (RULE13)

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state <= CBE_ST_IDLE;
      end
      else if (clk_en)
      begin
         unique case (state)
            CBE_ST_IDLE:
            begin
               if (req_valid)
               begin
                  state <= is_bit_op(req.op) ? CBE_ST_FETCH : CBE_ST_DECIDE;
               end
            end
            CBE_ST_FETCH: state <= CBE_ST_DECIDE;
            CBE_ST_DECIDE: state <= CBE_ST_IDLE;
            default: state <= CBE_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         cur <= '0;
      end
      else if (clk_en && req_valid && state == CBE_ST_IDLE)
      begin
         cur <= req;
      end
   end

   // ****************************************
   // Bit fetch
   // ****************************************
   // Byte read: user RAM for low addresses, SFR for the upper half.
   cbe_bit_ram #(.DEPTH(CBE_USER_BYTES), .WIDTH(CBE_DATA_W)) u_ram
   (
      .core_clk(core_clk),
      .clk_en(clk_en),
      .rd_addr(ram_idx),
      .rd_data(ram_rd),
      .wr_en(ram_we),
      .wr_addr(ram_waddr),
      .wr_data(ram_wdata)
   );

   assign sfr_addr = sfr_byte(cur.bit_addr);
   assign byte_val = in_sfr ? sfr_rd_data : ram_rd;
   assign bit_val = byte_val[cur.bit_addr[2:0]]; // see (RULE13)

   // ****************************************
   // Branch decision
   // ****************************************
   always_comb
   begin
      next_taken = 1'b0;
      next_clear = 1'b0;
      unique case (cur.op)
         CBE_OP_JUMP_IF_BIT_ONE: next_taken = bit_val; // see (RULE1)
         CBE_OP_JUMP_IF_BIT_ONE_THEN_CLEAR:
         begin
            next_taken = bit_val; // see (RULE2)
            next_clear = bit_val; // see (RULE2)
         end
         CBE_OP_JUMP_IF_BIT_ZERO: next_taken = !bit_val; // see (RULE3)
         CBE_OP_JUMP_ON_CARRY_SET: next_taken = carry_in; // see (RULE4)
         CBE_OP_JUMP_ON_CARRY_CLEAR: next_taken = !carry_in; // see (RULE5)
         CBE_OP_COMPARE_BRANCH_UNEQUAL:
            next_taken = cur.operand_a != cur.operand_b; // see (RULE6)
         // The accumulator itself is tested; there is no zero flag.
         CBE_OP_BRANCH_ACC_IS_ZERO:
            next_taken = acc == 8'h00; // see (RULE10) (RULE12)
         CBE_OP_BRANCH_ACC_NOT_ZERO:
            next_taken = |acc; // see (RULE11) (RULE12)
         default: next_taken = 1'b0;
      endcase
   end

   assign cleared_byte = byte_val & ~(8'h01 << cur.bit_addr[2:0]);

   // The clear is a read-modify-write of the whole byte, so other bits
   // of the byte keep the value that was just read.
   always_comb
   begin
      ram_we = ram_we_ext;
      ram_waddr = ram_addr_ext;
      ram_wdata = ram_wdata_ext;
      sfr_we = 1'b0;
      sfr_wr_data = 8'h00;
      // Gated by the enable so a frozen cycle does not repeat a strobe.
      if (clk_en && state == CBE_ST_DECIDE && next_clear)
      begin
         if (in_sfr)
         begin
            sfr_we = 1'b1; // see (RULE2) (RULE14)
            sfr_wr_data = cleared_byte;
         end
         else
         begin
            ram_we = 1'b1; // see (RULE2) (RULE13)
            ram_waddr = cur.bit_addr[6:3];
            ram_wdata = cleared_byte;
         end
      end
   end

   // ****************************************
   // Response register
   // ****************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         resp_valid <= 1'b0;
         resp <= '0;
      end
      else if (clk_en)
      begin
         resp_valid <= state == CBE_ST_DECIDE;
         if (state == CBE_ST_DECIDE)
         begin
            resp.taken <= next_taken;
            // Only the compare touches carry, taken or not.
            resp.carry_we <=
               cur.op == CBE_OP_COMPARE_BRANCH_UNEQUAL; // see (RULE9) (RULE15)
            resp.carry <= cur.operand_a < cur.operand_b; // see (RULE7) (RULE8)
            resp.length <= is_short_op(cur.op) ?
                           2'(CBE_JC_BYTES) : 2'(CBE_STD_BYTES); // see (RULE4)
         end
      end
   end

endmodule : cbe_branch_eval

//--- testbench/cbe_branch_eval_assertions.sv
// Port checker of the conditional branch evaluator.
`timescale 1ns/100ps
module cbe_chk
(
   input wire logic core_clk, // Clock.
   input wire logic rst_b, // Reset.
   input wire logic clk_en, // Run.
   input wire logic req_valid, // Request.
   input wire cbe_pkg::cbe_req_t req, // Body.
   input wire logic req_ready, // Ready.
   input wire logic carry_in, // Carry.
   input wire logic [7:0] acc, // Accumulator.
   input wire logic resp_valid, // Answer.
   input wire cbe_pkg::cbe_resp_t resp, // Decision.
   input wire logic [7:0] sfr_addr, // SFR byte.
   input wire logic [7:0] sfr_rd_data, // SFR read.
   input wire logic sfr_we, // SFR write.
   input wire logic [7:0] sfr_wr_data // SFR data.
);
   import cbe_pkg::*;
   cbe_req_t held;
   logic take;
   logic sbit;
   logic [2:0] bi;
   assign take = clk_en & req_valid & req_ready;
   assign bi = held.bit_addr[2:0];
   always_ff @(posedge core_clk)
   begin
      if (take)
         held <= req;
   end
   // The bit is sampled in the deciding cycle, on the same edge that raises the answer.
   always_ff @(posedge core_clk)
   begin
      sbit <= sfr_rd_data[bi];
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ****************************************
   // Assertions
   // ****************************************
   sequence s_bit_take;
      take && req.op inside {4'h1, 4'h2, 4'h3};
   endsequence
   sequence s_won;
      resp_valid && resp.taken;
   endsequence
   bit_answer_a: assert property (
      s_bit_take |-> ##1 !resp_valid [*2] ##1 resp_valid)
      else $error("bit answer late");
   fast_answer_a: assert property (
      take && req.op > 4'h3 |-> ##1 !resp_valid ##1 resp_valid)
      else $error("short answer late");
   answer_len_a: assert property (
      resp_valid |-> resp.length ==
      (held.op inside {4'h4, 4'h5, 4'h7, 4'h8} ? 2'd2 : 2'd3))
      else $error("wrong length");
   cmp_branch_a: assert property (
      resp_valid && held.op == 4'h6 |->
      resp.taken == (held.operand_a != held.operand_b))
      else $error("compare");
   cmp_carry_a: assert property (
      resp_valid && held.op == 4'h6 |->
      resp.carry_we && resp.carry == (held.operand_a < held.operand_b))
      else $error("compare carry");
   carry_kept_a: assert property (
      resp_valid && held.op != 4'h6 |-> !resp.carry_we)
      else $error("carry written");
   carry_test_a: assert property (
      resp_valid && held.op inside {4'h4, 4'h5} |->
      resp.taken == ($past(carry_in) ^ (held.op == 4'h5)))
      else $error("carry test");
   acc_test_a: assert property (
      resp_valid && held.op inside {4'h7, 4'h8} |->
      resp.taken == (($past(acc) == 8'h00) ^ (held.op == 4'h8)))
      else $error("acc test");
   sfr_bit_a: assert property (
      resp_valid && held.bit_addr[7] && held.op < 4'h4 |->
      resp.taken == (sbit ^ (held.op == 4'h3)))
      else $error("sfr bit test");
   sfr_clear_a: assert property (
      sfr_we |-> held.op == 4'h2 && sfr_rd_data[bi] &&
      sfr_addr == {held.bit_addr[7:3], 3'b000} &&
      sfr_wr_data == (sfr_rd_data & ~(8'h01 << bi)) ##1 s_won)
      else $error("bad sfr clear");
   sfr_clear_done_a: assert property (
      s_won && held.op == 4'h2 && held.bit_addr[7] |-> $past(sfr_we))
      else $error("sfr clear missing");
   sfr_byte_a: assert property (
      resp_valid && held.bit_addr[7] |->
      $past(sfr_addr) == {held.bit_addr[7:3], 3'b000})
      else $error("sfr byte address");
endmodule : cbe_chk
bind cbe_branch_eval cbe_chk u_chk (.core_clk(core_clk), .rst_b(rst_b),
   .clk_en(clk_en), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .carry_in(carry_in), .acc(acc), .resp_valid(resp_valid), .resp(resp),
   .sfr_addr(sfr_addr), .sfr_rd_data(sfr_rd_data), .sfr_we(sfr_we),
   .sfr_wr_data(sfr_wr_data));

//--- testbench/cbe_branch_eval_tb_top.sv
// Self-checking testbench of the conditional branch evaluator.
`timescale 1ns/100ps
module cbe_branch_eval_tb_top;
   import cbe_pkg::*;
   logic core_clk, rst_b, clk_en, req_valid, req_ready, carry_in, resp_valid;
   logic sfr_we, ram_we_ext;
   logic [7:0] acc, sfr_addr, sfr_wr_data, ram_wdata_ext, sfr_val, ba, a;
   logic [3:0] ram_addr_ext;
   logic [7:0] ram_m [16];
   cbe_req_t req;
   cbe_resp_t exp_q[$], resp, e_m;
   int errors, samples_checked;
   cbe_branch_eval u_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
      .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .carry_in(carry_in), .acc(acc), .resp_valid(resp_valid), .resp(resp),
      .sfr_addr(sfr_addr), .sfr_rd_data(sfr_val), .sfr_we(sfr_we),
      .sfr_wr_data(sfr_wr_data), .ram_we_ext(ram_we_ext),
      .ram_addr_ext(ram_addr_ext), .ram_wdata_ext(ram_wdata_ext));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      if (errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic wait_for(input logic ans);
      for (int i = 0; i < 20; i++)
      begin
         @(posedge core_clk);
         if ((ans ? resp_valid : req_ready) === 1'b1)
            return;
      end
      $display("Error at %0t: handshake timed out", $time);
      errors++;
      print_verdict();
   endtask : wait_for
   // The model copy is only updated when the write is meant to land.
   task automatic ram_write(input logic [3:0] ad, input logic [7:0] d,
                            input logic en);
      @(posedge core_clk);
      ram_we_ext <= 1'b1;
      ram_addr_ext <= ad;
      ram_wdata_ext <= d;
      if (en)
         ram_m[ad] = d;
      @(posedge core_clk);
      ram_we_ext <= 1'b0;
      ram_wdata_ext <= ~d;
   endtask : ram_write
   // Expectation is noted before the request, from the model's bit copy.
   task automatic issue(input logic [3:0] op, input logic [7:0] b, ac,
                        input logic c);
      cbe_resp_t e;
      logic bv;
      bv = ba[7] ? sfr_val[ba[2:0]] : ram_m[ba[6:3]][ba[2:0]];
      case (op)
         4'h1, 4'h2: e.taken = bv;
         4'h3: e.taken = !bv;
         4'h4: e.taken = c;
         4'h5: e.taken = !c;
         4'h6: e.taken = a != b;
         4'h7: e.taken = ac == 8'h00;
         default: e.taken = ac != 8'h00;
      endcase
      e.carry_we = op == 4'h6;
      e.carry = op == 4'h6 && a < b;
      e.length = op inside {4'h4, 4'h5, 4'h7, 4'h8} ? 2'd2 : 2'd3;
      if (op == 4'h2 && bv && !ba[7])
         ram_m[ba[6:3]][ba[2:0]] = 1'b0;
      exp_q.push_back(e);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req <= '{cbe_op_t'(op), ba, a, b};
      acc <= ac;
      carry_in <= c;
      wait_for(1'b0);
      req_valid <= 1'b0;
      wait_for(1'b1);
   endtask : issue
   always @(posedge core_clk)
   begin
      if (sfr_we === 1'b1)
         sfr_val <= sfr_wr_data;
      if (rst_b && clk_en && resp_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            $display("Error at %0t: answer with nothing expected", $time);
            errors++;
         end
         else
         begin
            e_m = exp_q.pop_front();
            check(resp.taken, e_m.taken);
            check(resp.length, e_m.length);
            check(resp.carry_we, e_m.carry_we);
            if (e_m.carry_we)
               check(resp.carry, e_m.carry);
         end
      end
   end
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // ****************************************
   // Stimulus
   // ****************************************
   initial
   begin
      errors = 0;
      samples_checked = 0;
      void'($urandom(32'h0be6bb0d));
      {rst_b, clk_en, req_valid, carry_in, ram_we_ext} = 5'b01000;
      {acc, ram_addr_ext, ram_wdata_ext, sfr_val, ba, a} = '0;
      req = '0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 16; i++)
         ram_write(4'(i), 8'($urandom()), 1'b1);
      // A bit address stays for a group of eight, so a clear is seen later.
      for (int i = 0; i < 640; i++)
      begin
         if (i % 8 == 0)
         begin
            ba = 8'($urandom());
            sfr_val <= 8'($urandom());
            // With the enable low the RAM must ignore this write.
            clk_en <= 1'b0;
            ram_write(ba[6:3], 8'($urandom()), 1'b0);
            clk_en <= 1'b1;
            ram_write(4'($urandom()), 8'($urandom()), 1'b1);
         end
         a = 8'($urandom());
         issue(4'(i % 8 + 1), $urandom_range(1) ? a : 8'($urandom()),
               $urandom_range(1) ? 8'h00 : 8'($urandom()), 1'($urandom()));
      end
      @(posedge core_clk);
      print_verdict();
   end
endmodule : cbe_branch_eval_tb_top
